// ### hw/dsf_defs.svh
`ifndef DSF_DEFS_SVH
`define DSF_DEFS_SVH

// parameter indexes of the degrade permissions
`define DSF_IDX_SPEED_PERMIT     16'hfa0c
`define DSF_IDX_PRIMARY_PERMIT   16'hfa0d
`define DSF_IDX_SECONDARY_PERMIT 16'hfa0e
`define DSF_IDX_WHEEL_PERMIT     16'hfa0f

// permission encoding and reset value
`define DSF_PERMIT_FALSE         8'h00
`define DSF_PERMIT_TRUE          8'hff
`define DSF_PERMIT_RESET         8'h00

// speed substituted while no valid value exists (0.1 km/h units)
`define DSF_SPEED_MAX_DEFAULT    16'h03e8

`endif

// ### hw/dsf_pkg.sv
package dsf_pkg;

    typedef enum logic [1:0] {
        DSF_OPERATIONAL,
        DSF_REDUCED,
        DSF_FAILSAFE
    } dsf_state_t;

    // one bit per degradable fault source
    typedef struct packed {
        logic primary;
        logic secondary;
        logic speed;
        logic wheel_angle;
    } dsf_src_t;

    // reductions applied to the steering datapaths
    typedef struct packed {
        logic primary_disabled;
        logic secondary_disabled;
        logic speed_sens_bypass;
        logic speed_ramp_bypass;
        logic speed_cond_ignore;
        logic soft_stop_bypass;
        logic actuator_sens_bypass;
        logic closed_loop_inhibit;
    } dsf_reduce_t;

endpackage : dsf_pkg

// ### hw/dsf_fault_handler.sv
`timescale 1ns/1ps
`include "dsf_defs.svh"
// Behaviour
// (RULE1) primary permit 255 sends primary device faults to reduced state; default 0.
// (RULE2) primary-caused reduction disables primary device and refuses later enables.
// (RULE3) a fault on a source whose permit is false enters the fault state.
// (RULE4) device permits cover analogue and CAN-connected steering devices alike.
// (RULE5) secondary permit 255 sends secondary device faults to reduced state; default 0.
// (RULE6) secondary-caused reduction disables secondary device and rejects later enables.
// (RULE7) speed permit 255 sends vehicle speed faults to reduced state; default 0.
// (RULE8) speed reduction bypasses speed sensitivity, substituting maximum speed.
// (RULE9) speed reduction bypasses speed ramps, assuming maximum speed.
// (RULE10) speed reduction treats the program transition speed condition as met.
// (RULE11) speed fault touches only speed consumers; devices keep operating.
// (RULE12) wheel-angle permit true sends wheel angle faults to reduced state.
// (RULE13) wheel-angle reduction bypasses soft-stop and actuator-position sensitivity.
// (RULE14) wheel-angle reduction blocks closed-loop control for all set-point sources.
// (RULE15) wheel-angle fault touches only angle consumers; devices keep working.
// (RULE16) fault state disables the magnetic valve bridge.
// (RULE17) wheel-angle permit uses 0/255 encoding and resets to false.
// (RULE18) several permitted faults together apply the union of reductions.
module dsf_fault_handler #(
    parameter logic [15:0] SPEED_MAX = `DSF_SPEED_MAX_DEFAULT
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    // parameter access
    input  wire logic                 param_wr_en,
    input  wire logic [15:0]          param_wr_index,
    input  wire logic [7:0]           param_wr_data,
    output logic                      param_wr_ok,
    input  wire logic [15:0]          param_rd_index,
    output logic [7:0]                param_rd_data,
    output logic                      param_rd_hit,
    // fault reports from the detectors, levels
    input  wire logic                 fault_primary_analog,
    input  wire logic                 fault_primary_can,
    input  wire logic                 fault_secondary_analog,
    input  wire logic                 fault_secondary_can,
    input  wire logic                 fault_speed,
    input  wire logic                 fault_wheel_angle,
    input  wire logic                 fault_critical,
    // enable requests from the device enable control
    input  wire logic                 primary_enable_req,
    input  wire logic                 secondary_enable_req,
    output logic                      primary_active,
    output logic                      secondary_active,
    // vehicle speed path
    input  wire logic                 speed_valid,
    input  wire logic [15:0]          speed_in,
    output logic [15:0]               speed_used,
    // state and reductions
    output dsf_pkg::dsf_state_t       state,
    output dsf_pkg::dsf_reduce_t      reduce,
    output dsf_pkg::dsf_src_t         reduce_cause,
    output logic                      valve_bridge_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // degrade permissions

    logic [7:0] speed_fault_degrade_permit;
    logic [7:0] primary_device_degrade_permit;
    logic [7:0] secondary_device_degrade_permit;
    logic [7:0] wheel_angle_degrade_permit;

    wire logic wr_legal_value = (param_wr_data == `DSF_PERMIT_FALSE) ||
                                (param_wr_data == `DSF_PERMIT_TRUE);
    // configuration is locked once in the fault state
    wire logic wr_allowed     = param_wr_en && wr_legal_value && (state != dsf_pkg::DSF_FAILSAFE);
    wire logic wr_speed       = wr_allowed && (param_wr_index == `DSF_IDX_SPEED_PERMIT);
    wire logic wr_primary     = wr_allowed && (param_wr_index == `DSF_IDX_PRIMARY_PERMIT);
    wire logic wr_secondary   = wr_allowed && (param_wr_index == `DSF_IDX_SECONDARY_PERMIT);
    wire logic wr_wheel       = wr_allowed && (param_wr_index == `DSF_IDX_WHEEL_PERMIT);
    wire logic wr_hit         = wr_speed || wr_primary || wr_secondary || wr_wheel;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            speed_fault_degrade_permit      <= `DSF_PERMIT_RESET; // RULE7
            primary_device_degrade_permit   <= `DSF_PERMIT_RESET; // RULE1
            secondary_device_degrade_permit <= `DSF_PERMIT_RESET; // RULE5
            wheel_angle_degrade_permit      <= `DSF_PERMIT_RESET; // RULE17
            param_wr_ok                     <= 1'b0;
        end else begin
            if (wr_speed) speed_fault_degrade_permit <= param_wr_data;
            if (wr_primary) primary_device_degrade_permit <= param_wr_data;
            if (wr_secondary) secondary_device_degrade_permit <= param_wr_data;
            if (wr_wheel) wheel_angle_degrade_permit <= param_wr_data; // RULE17
            param_wr_ok <= wr_hit;
        end
    end

    wire logic rd_speed     = (param_rd_index == `DSF_IDX_SPEED_PERMIT);
    wire logic rd_primary   = (param_rd_index == `DSF_IDX_PRIMARY_PERMIT);
    wire logic rd_secondary = (param_rd_index == `DSF_IDX_SECONDARY_PERMIT);
    wire logic rd_wheel     = (param_rd_index == `DSF_IDX_WHEEL_PERMIT);
    wire logic [7:0] rd_mux = rd_speed     ? speed_fault_degrade_permit :
                              rd_primary   ? primary_device_degrade_permit :
                              rd_secondary ? secondary_device_degrade_permit :
                              rd_wheel     ? wheel_angle_degrade_permit : 8'h00;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            param_rd_data <= 8'h00;
            param_rd_hit  <= 1'b0;
        end else begin
            param_rd_data <= rd_mux;
            param_rd_hit  <= rd_speed || rd_primary || rd_secondary || rd_wheel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault classification

    // only the exact true code permits degradation; anything else acts as false
    wire logic permit_speed     = (speed_fault_degrade_permit == `DSF_PERMIT_TRUE);
    wire logic permit_primary   = (primary_device_degrade_permit == `DSF_PERMIT_TRUE);
    wire logic permit_secondary = (secondary_device_degrade_permit == `DSF_PERMIT_TRUE);
    wire logic permit_wheel     = (wheel_angle_degrade_permit == `DSF_PERMIT_TRUE);

    wire logic any_primary   = fault_primary_analog || fault_primary_can;     // RULE4
    wire logic any_secondary = fault_secondary_analog || fault_secondary_can; // RULE4

    dsf_pkg::dsf_src_t fault_now;
    dsf_pkg::dsf_src_t permit_now;
    assign fault_now  = '{primary: any_primary, secondary: any_secondary,
                          speed: fault_speed, wheel_angle: fault_wheel_angle};
    assign permit_now = '{primary: permit_primary, secondary: permit_secondary,
                          speed: permit_speed, wheel_angle: permit_wheel};

    // permission is judged when the fault is seen; later permit writes do not undo it
    wire logic [3:0] fault_bits  = fault_now;
    wire logic [3:0] permit_bits = permit_now;
    wire logic [3:0] degrade_new = fault_bits & permit_bits;        // RULE1 RULE5 RULE7 RULE12
    wire logic       go_failsafe = fault_critical ||
                                   |(fault_bits & ~permit_bits);    // RULE3

    dsf_pkg::dsf_src_t next_cause;
    dsf_pkg::dsf_state_t next_state;
    // causes only accumulate until rstn reset; set always wins
    assign next_cause = dsf_pkg::dsf_src_t'(reduce_cause | degrade_new); // RULE18

    always_comb begin
        next_state = state;
        unique case (state)
            dsf_pkg::DSF_OPERATIONAL: begin
                if (go_failsafe) next_state = dsf_pkg::DSF_FAILSAFE;        // RULE3
                else if (|degrade_new) next_state = dsf_pkg::DSF_REDUCED;   // RULE1 RULE5 RULE7 RULE12
            end
            dsf_pkg::DSF_REDUCED: begin
                if (go_failsafe) next_state = dsf_pkg::DSF_FAILSAFE;        // RULE3
            end
            dsf_pkg::DSF_FAILSAFE: begin
                next_state = dsf_pkg::DSF_FAILSAFE;
            end
            default: begin
                next_state = dsf_pkg::DSF_FAILSAFE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state        <= dsf_pkg::DSF_OPERATIONAL;
            reduce_cause <= '0;
        end else begin
            state        <= next_state;
            reduce_cause <= next_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reductions, each tied to its own cause only

    dsf_pkg::dsf_reduce_t next_reduce;
    assign next_reduce.primary_disabled     = next_cause.primary;      // RULE2
    assign next_reduce.secondary_disabled   = next_cause.secondary;    // RULE6
    assign next_reduce.speed_sens_bypass    = next_cause.speed;        // RULE8 RULE11
    assign next_reduce.speed_ramp_bypass    = next_cause.speed;        // RULE9 RULE11
    assign next_reduce.speed_cond_ignore    = next_cause.speed;        // RULE10
    assign next_reduce.soft_stop_bypass     = next_cause.wheel_angle;  // RULE13 RULE15
    assign next_reduce.actuator_sens_bypass = next_cause.wheel_angle;  // RULE13 RULE15
    assign next_reduce.closed_loop_inhibit  = next_cause.wheel_angle;  // RULE14

    // enable requests pass unless their own device is reduced away or the next state is failsafe
    wire logic next_primary_active   = primary_enable_req && !next_cause.primary &&
                                       (next_state != dsf_pkg::DSF_FAILSAFE);      // RULE2
    wire logic next_secondary_active = secondary_enable_req && !next_cause.secondary &&
                                       (next_state != dsf_pkg::DSF_FAILSAFE);      // RULE6
    wire logic [15:0] next_speed_used = (next_cause.speed || !speed_valid) ?
                                        SPEED_MAX : speed_in;                      // RULE8 RULE9

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reduce              <= '0;
            primary_active      <= 1'b0;
            secondary_active    <= 1'b0;
            speed_used          <= 16'h0000;
            valve_bridge_enable <= 1'b0;
        end else begin
            reduce              <= next_reduce;                            // RULE18
            primary_active      <= next_primary_active;
            secondary_active    <= next_secondary_active;
            speed_used          <= next_speed_used;
            valve_bridge_enable <= (next_state != dsf_pkg::DSF_FAILSAFE);  // RULE16
        end
    end

endmodule : dsf_fault_handler

// ### verification/dsf_fault_handler_sva.sv
`timescale 1ns/1ps
`include "dsf_defs.svh"
module dsf_checker #(
    parameter logic [15:0] SPEED_MAX = `DSF_SPEED_MAX_DEFAULT
) (
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    // stimulus seen at the ports
    input wire logic                 param_wr_en,
    input wire logic [7:0]           param_wr_data,
    input wire logic                 param_wr_ok,
    input wire logic [15:0]          param_rd_index,
    input wire logic                 param_rd_hit,
    input wire logic                 fault_primary_analog,
    input wire logic                 fault_primary_can,
    input wire logic                 fault_critical,
    // results
    input wire logic                 primary_active,
    input wire logic                 secondary_active,
    input wire logic [15:0]          speed_used,
    input wire dsf_pkg::dsf_state_t  state,
    input wire dsf_pkg::dsf_reduce_t reduce,
    input wire dsf_pkg::dsf_src_t    reduce_cause,
    input wire logic                 valve_bridge_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_bad_wr;
        param_wr_en && !(param_wr_data inside {8'h00, 8'hff});
    endsequence
    sequence s_fail;
        state == dsf_pkg::DSF_FAILSAFE;
    endsequence
    property p_bad_wr; s_bad_wr |=> !param_wr_ok; endproperty
    property p_crit; fault_critical |=> s_fail; endproperty
    property p_sticky; s_fail |=> s_fail; endproperty
    property p_bridge; s_fail |-> !valve_bridge_enable; endproperty
    property p_prim_cause;
        $rose(reduce_cause.primary) |-> $past(fault_primary_analog || fault_primary_can);
    endproperty
    property p_prim_off; reduce_cause.primary |-> !primary_active; endproperty
    property p_sec_off; reduce_cause.secondary |-> !secondary_active; endproperty
    property p_speed;
        reduce_cause.speed |-> reduce.speed_sens_bypass && reduce.speed_ramp_bypass
            && reduce.speed_cond_ignore && speed_used == SPEED_MAX;
    endproperty
    // all three angle flags together must be set exactly when the angle cause is set
    property p_wheel;
        reduce_cause.wheel_angle == (reduce.soft_stop_bypass && reduce.actuator_sens_bypass
            && reduce.closed_loop_inhibit);
    endproperty
    property p_rd_hit; param_rd_index == `DSF_IDX_WHEEL_PERMIT |=> param_rd_hit; endproperty
    a_bad_wr: assert property (p_bad_wr) else $error("odd permit value taken");
    a_crit: assert property (p_crit) else $error("critical fault not failsafe");
    a_sticky: assert property (p_sticky) else $error("failsafe left");
    a_bridge: assert property (p_bridge) else $error("bridge on in failsafe");
    a_prim_cause: assert property (p_prim_cause) else $error("cause without fault");
    a_prim_off: assert property (p_prim_off) else $error("primary still active");
    a_sec_off: assert property (p_sec_off) else $error("secondary still active");
    a_speed: assert property (p_speed) else $error("speed bypass wrong");
    a_wheel: assert property (p_wheel) else $error("angle bypass wrong");
    a_rd_hit: assert property (p_rd_hit) else $error("angle permit unmapped");
endmodule : dsf_checker
bind dsf_fault_handler dsf_checker #(.SPEED_MAX(SPEED_MAX)) u_chk (.clk_sys, .rstn,
    .param_wr_en, .param_wr_data, .param_wr_ok, .param_rd_index, .param_rd_hit,
    .fault_primary_analog, .fault_primary_can, .fault_critical, .primary_active,
    .secondary_active, .speed_used, .state, .reduce, .reduce_cause, .valve_bridge_enable);

// ### verification/dsf_sensor_model.sv
`timescale 1ns/1ps
// detectors report one cycle after the cause, like a sampled sensor check
module dsf_sensor_model (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [6:0] inject,
    output logic [6:0]      faults
);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            faults <= 7'h00;
        end else begin
            faults <= inject;
        end
    end
endmodule : dsf_sensor_model

// ### verification/test_degraded_steering_fault_handler.sv
`timescale 1ns/1ps
module test_degraded_steering_fault_handler;
    localparam logic [15:0] SMAX = 16'h0123;
    logic        clk_sys = 1'b0, rstn = 1'b0, param_wr_en = 1'b0;
    logic [15:0] param_wr_index = 16'h0, param_rd_index = 16'h0, speed_in = 16'h0456;
    logic [7:0]  param_wr_data = 8'h00, param_rd_data;
    logic        primary_enable_req = 1'b1, secondary_enable_req = 1'b1, speed_valid = 1'b1;
    logic        param_wr_ok, param_rd_hit, primary_active, secondary_active;
    logic        valve_bridge_enable;
    logic [15:0] speed_used;
    logic [6:0]  inject = 7'h00, faults;
    dsf_pkg::dsf_state_t  state;
    dsf_pkg::dsf_reduce_t reduce;
    dsf_pkg::dsf_src_t    reduce_cause;
    int          n_fail = 0, checks = 0;
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    dsf_sensor_model u_sensors (.clk_sys, .rstn, .inject, .faults);
    dsf_fault_handler #(.SPEED_MAX(SMAX)) DUT (.clk_sys, .rstn, .param_wr_en,
        .param_wr_index, .param_wr_data, .param_wr_ok, .param_rd_index, .param_rd_data,
        .param_rd_hit, .fault_primary_analog(faults[6]), .fault_primary_can(faults[5]),
        .fault_secondary_analog(faults[4]), .fault_secondary_can(faults[3]),
        .fault_speed(faults[2]), .fault_wheel_angle(faults[1]), .fault_critical(faults[0]),
        .primary_enable_req, .secondary_enable_req, .primary_active, .secondary_active,
        .speed_valid, .speed_in, .speed_used, .state, .reduce, .reduce_cause,
        .valve_bridge_enable);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic do_reset();
        @(posedge clk_sys);
        rstn <= 1'b0;
        inject <= 7'h00;
        speed_valid <= 1'b1;
        primary_enable_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask : do_reset
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic ok);
        @(posedge clk_sys);
        param_wr_en <= 1'b1;
        param_wr_index <= idx;
        param_wr_data <= d;
        @(posedge clk_sys);
        param_wr_en <= 1'b0;
        #1 chk("param_wr_ok", {15'h0, param_wr_ok}, {15'h0, ok});
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic hit);
        @(posedge clk_sys);
        param_rd_index <= idx;
        @(posedge clk_sys);
        #1 chk("param_rd_data", {8'h0, param_rd_data}, {8'h0, d});
        chk("param_rd_hit", {15'h0, param_rd_hit}, {15'h0, hit});
    endtask : rd
    // detector register plus handler register: results settle after the second edge
    task automatic hit_faults(input logic [6:0] f);
        @(posedge clk_sys);
        inject <= f;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : hit_faults
    task automatic outs(input logic [1:0] st, input logic [3:0] c, input logic [7:0] r);
        chk("state", {14'h0, state}, {14'h0, st});
        chk("reduce_cause", {12'h0, reduce_cause}, {12'h0, c});
        chk("reduce", {8'h0, reduce}, {8'h0, r});
    endtask : outs
    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        for (int i = 0; i < 5; i++) begin
            rd(16'hfa0c + 16'(i), 8'h00, i < 4);
        end
        wr(16'hfa0f, 8'h12, 1'b0);
        rd(16'hfa0f, 8'h00, 1'b1);
        $display("test reset values done");
        wr(16'hfa0c, 8'hff, 1'b1);
        wr(16'hfa0d, 8'hff, 1'b1);
        rd(16'hfa0d, 8'hff, 1'b1);
        hit_faults(7'b0100100);
        outs(dsf_pkg::DSF_REDUCED, 4'ha, 8'hb8);
        chk("primary_active", {15'h0, primary_active}, 16'h0000);
        chk("secondary_active", {15'h0, secondary_active}, 16'h0001);
        chk("speed_used", speed_used, SMAX);
        chk("valve_bridge_enable", {15'h0, valve_bridge_enable}, 16'h0001);
        $display("test primary and speed done");
        do_reset();
        wr(16'hfa0e, 8'hff, 1'b1);
        wr(16'hfa0f, 8'hff, 1'b1);
        hit_faults(7'b0010010);
        outs(dsf_pkg::DSF_REDUCED, 4'h5, 8'h47);
        chk("primary_active", {15'h0, primary_active}, 16'h0001);
        chk("speed_used", speed_used, 16'h0456);
        chk("secondary_active", {15'h0, secondary_active}, 16'h0000);
        @(posedge clk_sys);
        speed_valid <= 1'b0;
        primary_enable_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("speed_used", speed_used, SMAX);
        chk("primary_active", {15'h0, primary_active}, 16'h0000);
        $display("test secondary and angle done");
        // unpermitted speed fault alone, so the permit check itself must act
        do_reset();
        hit_faults(7'b0000100);
        outs(dsf_pkg::DSF_FAILSAFE, 4'h0, 8'h00);
        chk("valve_bridge_enable", {15'h0, valve_bridge_enable}, 16'h0000);
        wr(16'hfa0c, 8'hff, 1'b0);
        rd(16'hfa0c, 8'h00, 1'b1);
        $display("test failsafe done");
        do_reset();
        hit_faults(7'b0000001);
        outs(dsf_pkg::DSF_FAILSAFE, 4'h0, 8'h00);
        chk("primary_active", {15'h0, primary_active}, 16'h0000);
        chk("valve_bridge_enable", {15'h0, valve_bridge_enable}, 16'h0000);
        $display("test critical done");
        results();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        results();
    end
endmodule : test_degraded_steering_fault_handler
